// >>> pkg/pll_ctrl_pkg.sv
// constants, types and strap decode for the pll clock generator control
// Summary of operation
// - input halve bit halves reference into pll
// - straps at power-up pick 6, 32, 16
// - six-bit software multiplier, rewritable at runtime
// - multiplier N gives Nx, zero gives 64x
// - reset loads multiplier from strap ratio
// - new divisor adopted smoothly within 14 core clock cycles
// - core clock is vco over divisor field, or over one when the field is zero or its enable is off
// - output divisor field resets to one
// - peripheral clock is core clock over two
// - bypass routes reference straight to core clock
// - bypass switch is clean, no vco feedback
// - per-peripheral clock disables save power
// - peripheral clocks stay off after reset
// - internal reset held 4096 reference cycles
package pll_ctrl_pkg;
    localparam int MULT_W = 6;
    localparam int FB_MULT_W = 7;
    localparam logic [6:0] MULT_ZERO_EQUIV = 7'h40;
    localparam logic [5:0] RATIO_STRAP_00 = 6'h06;
    localparam logic [5:0] RATIO_STRAP_01 = 6'h20;
    localparam logic [5:0] RATIO_STRAP_10 = 6'h10;
    localparam logic [5:0] RATIO_STRAP_RSVD = 6'h06;
    localparam logic [5:0] MULT_RESET = 6'h06;
    localparam int DIV_W = 4;
    localparam logic [3:0] DIV_RESET = 4'h1;
    localparam logic [3:0] DIV_ONE = 4'h1;
    localparam int NUM_PERIPH = 8;
    localparam logic [7:0] PDN_RESET = 8'hff;
    localparam int SETTLE_W = 13;
    localparam logic [12:0] RST_DELAY_CYCLES = 13'h1000;
    localparam logic [5:0] SWITCH_WAIT = 6'h3f;
    localparam int TRANSITION_CORE_CLOCK = 14;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_STRAP = 2'b01,
        ST_SETTLE = 2'b10,
        ST_RUN = 2'b11
    } seq_state_t;

    function automatic logic [5:0] strap_ratio(input logic [1:0] s);
        logic [5:0] r;
        r = RATIO_STRAP_RSVD;
        case (s)
            2'b00: r = RATIO_STRAP_00;
            2'b01: r = RATIO_STRAP_01;
            2'b10: r = RATIO_STRAP_10;
            default: r = RATIO_STRAP_RSVD;
        endcase
        return r;
    endfunction
endpackage

// >>> pkg/clk_tick_if.sv
// source tick, divisor and core tick shared by the clock generator parts
`timescale 1ns/10ps
interface clk_tick_if
    import pll_ctrl_pkg::*;
();
    logic src_tick;
    logic [DIV_W-1:0] divisor;
    logic core_tick;
    modport ctrl(output src_tick, output divisor, input core_tick);
    modport divider(input src_tick, input divisor, output core_tick);
    modport gates(input core_tick);
endinterface

// >>> hdl/core_clock_divider.sv
// output divider that forms core clock ticks from source ticks
`timescale 1ns/10ps
module core_clock_divider
    import pll_ctrl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    clk_tick_if.divider tick
);
    logic [DIV_W-1:0] cnt_ff;
    logic core_tick_ff;
    logic wrap;

    // a new divisor is compared at every source tick, so it is taken on
    // the fly at the next period end without stopping the clock
    assign wrap = ({1'b0, cnt_ff} + 5'h01) >= {1'b0, tick.divisor};

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_ff <= '0;
            core_tick_ff <= 1'b0;
        end else begin
            core_tick_ff <= 1'b0;
            if (tick.src_tick) begin
                if (wrap) begin
                    cnt_ff <= '0;
                    core_tick_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 4'h1;
                end
            end
        end
    end

    assign tick.core_tick = core_tick_ff;

    div_wrap_tick_a: assert property (@(posedge i_clk) disable iff (i_rst)
        tick.src_tick && wrap |=> tick.core_tick)
        else $error("core tick missing at divider wrap");
    div_no_spur_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !tick.src_tick |=> !tick.core_tick)
        else $error("core tick without a source tick");
    div_by_four_c: cover property (@(posedge i_clk) disable iff (i_rst)
        tick.core_tick && tick.divisor == 4'h4);
endmodule

// >>> hdl/periph_clock_gates.sv
// fixed divide by two for the peripheral clock and per-peripheral gates
`timescale 1ns/10ps
module periph_clock_gates
    import pll_ctrl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    clk_tick_if.gates tick,
    input wire logic [NUM_PERIPH-1:0] i_pdn,
    output logic o_periph_tick,
    output logic [NUM_PERIPH-1:0] o_gated
);
    logic phase_ff;
    logic periph_tick_ff;
    logic [NUM_PERIPH-1:0] gated_ff;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            phase_ff <= 1'b0;
        end else if (tick.core_tick) begin
            phase_ff <= ~phase_ff;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            periph_tick_ff <= 1'b0;
        end else begin
            periph_tick_ff <= tick.core_tick & phase_ff;
        end
    end

    for (genvar g = 0; g < NUM_PERIPH; g++) begin : gen_gate
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                gated_ff[g] <= 1'b0;
            end else begin
                gated_ff[g] <= tick.core_tick & phase_ff & ~i_pdn[g];
            end
        end
    end

    assign o_periph_tick = periph_tick_ff;
    assign o_gated = gated_ff;

    periph_half_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_periph_tick |-> $past(tick.core_tick) && $past(phase_ff))
        else $error("peripheral tick not on every second core tick");
    gate_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_pdn[0] |=> !o_gated[0])
        else $error("disabled peripheral clock still ticking");
    periph_tick_c: cover property (@(posedge i_clk) disable iff (i_rst)
        o_periph_tick ##[1:40] o_periph_tick);
endmodule

// >>> hdl/pll_clock_generator_control.sv
// digital control around the pll: straps, multiplier, bypass, dividers
`timescale 1ns/10ps
module pll_clock_generator_control
    import pll_ctrl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_reference_input_clock,
    input wire logic i_vco_clock,
    input wire logic [1:0] i_ratio_strap,
    input wire logic i_input_halve_enable,
    input wire logic i_pll_bypass_select,
    input wire logic i_output_divisor_enable,
    input wire logic i_mult_wr,
    input wire logic [MULT_W-1:0] i_mult_val,
    input wire logic i_div_wr,
    input wire logic [DIV_W-1:0] i_div_val,
    input wire logic i_pdn_wr,
    input wire logic [NUM_PERIPH-1:0] i_pdn_val,
    output logic [FB_MULT_W-1:0] o_pll_feedback_multiplier,
    output logic o_input_halve_enable,
    output logic o_pll_ref_tick,
    output logic o_core_clock,
    output logic o_periph_clock,
    output logic [NUM_PERIPH-1:0] o_periph_clock_gated,
    output logic o_core_reset,
    output logic o_bypass_active,
    output logic [MULT_W-1:0] o_multiplier_field,
    output logic [DIV_W-1:0] o_divisor_field,
    output logic [NUM_PERIPH-1:0] o_periph_pdn
);
    logic ref_s1_ff;
    logic ref_s2_ff;
    logic ref_s3_ff;
    logic vco_s1_ff;
    logic vco_s2_ff;
    logic vco_s3_ff;
    logic [1:0] strap_s1_ff;
    logic [1:0] strap_s2_ff;
    logic ref_rise;
    logic vco_rise;

    seq_state_t state_ff;
    seq_state_t nxt_state;
    logic [SETTLE_W-1:0] settle_cnt_ff;
    logic core_reset_ff;

    logic [MULT_W-1:0] mult_ff;
    logic [FB_MULT_W-1:0] fb_mult_ff;
    logic [FB_MULT_W-1:0] nxt_fb_mult;

    logic halve_ff;
    logic halve_phase_ff;
    logic ref_tick_ff;

    logic [DIV_W-1:0] div_ff;
    logic output_divisor_enable_ff;
    logic [DIV_W-1:0] eff_div;

    logic bypass_ff;
    logic [5:0] sw_wait_ff;
    logic switch_now;

    logic [NUM_PERIPH-1:0] pdn_ff;

    clk_tick_if tick();

    // pins from outside this clock domain pass two flops first
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ref_s1_ff <= 1'b0;
            ref_s2_ff <= 1'b0;
            ref_s3_ff <= 1'b0;
            vco_s1_ff <= 1'b0;
            vco_s2_ff <= 1'b0;
            vco_s3_ff <= 1'b0;
        end else begin
            ref_s1_ff <= i_reference_input_clock;
            ref_s2_ff <= ref_s1_ff;
            ref_s3_ff <= ref_s2_ff;
            vco_s1_ff <= i_vco_clock;
            vco_s2_ff <= vco_s1_ff;
            vco_s3_ff <= vco_s2_ff;
        end
    end

    // straps keep sampling through reset so they are valid at release
    always_ff @(posedge i_clk) begin
        strap_s1_ff <= i_ratio_strap;
        strap_s2_ff <= strap_s1_ff;
    end

    assign ref_rise = ref_s2_ff & ~ref_s3_ff;
    assign vco_rise = vco_s2_ff & ~vco_s3_ff;

    // reset sequencing: catch straps, then let the pll settle
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_HOLD: begin
                nxt_state = ST_STRAP;
            end
            ST_STRAP: begin
                nxt_state = ST_SETTLE;
            end
            ST_SETTLE: begin
                if (settle_cnt_ff == RST_DELAY_CYCLES) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                nxt_state = ST_RUN;
            end
            default: begin
                nxt_state = ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_ff <= ST_HOLD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            settle_cnt_ff <= '0;
        end else if (state_ff != ST_RUN && ref_rise &&
                     settle_cnt_ff != RST_DELAY_CYCLES) begin
            settle_cnt_ff <= settle_cnt_ff + 13'h0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            core_reset_ff <= 1'b1;
        end else begin
            core_reset_ff <= (state_ff != ST_RUN);
        end
    end

    // multiplier field: strap ratio once after reset, software after that
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mult_ff <= MULT_RESET;
        end else if (state_ff == ST_STRAP) begin
            mult_ff <= strap_ratio(strap_s2_ff);
        end else if (i_mult_wr) begin
            mult_ff <= i_mult_val;
        end
    end

    always_comb begin
        if (mult_ff == '0) begin
            nxt_fb_mult = MULT_ZERO_EQUIV;
        end else begin
            nxt_fb_mult = {1'b0, mult_ff};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fb_mult_ff <= {1'b0, MULT_RESET};
        end else begin
            fb_mult_ff <= nxt_fb_mult;
        end
    end

    // input halving; software is expected to be bypassed while it flips
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            halve_ff <= 1'b0;
        end else begin
            halve_ff <= i_input_halve_enable;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            halve_phase_ff <= 1'b0;
        end else if (!halve_ff) begin
            halve_phase_ff <= 1'b0;
        end else if (ref_rise) begin
            halve_phase_ff <= ~halve_phase_ff;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ref_tick_ff <= 1'b0;
        end else begin
            ref_tick_ff <= ref_rise & (~halve_ff | halve_phase_ff);
        end
    end

    // output divisor field and its enable
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_ff <= DIV_RESET;
        end else if (i_div_wr) begin
            div_ff <= i_div_val;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            output_divisor_enable_ff <= 1'b0;
        end else begin
            output_divisor_enable_ff <= i_output_divisor_enable;
        end
    end

    always_comb begin
        if (!output_divisor_enable_ff || div_ff == '0) begin
            eff_div = DIV_ONE;
        end else begin
            eff_div = div_ff;
        end
    end

    // bypass only changes at a core tick boundary, or after a bounded
    // wait in case the current source has stopped
    assign switch_now = tick.core_tick || sw_wait_ff == SWITCH_WAIT;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bypass_ff <= 1'b0;
            sw_wait_ff <= '0;
        end else if (i_pll_bypass_select != bypass_ff) begin
            if (switch_now) begin
                bypass_ff <= i_pll_bypass_select;
                sw_wait_ff <= '0;
            end else begin
                sw_wait_ff <= sw_wait_ff + 6'h01;
            end
        end else begin
            sw_wait_ff <= '0;
        end
    end

    // bypass feeds the raw reference through with a divide of one
    assign tick.src_tick = bypass_ff ? ref_rise : vco_rise;
    assign tick.divisor = bypass_ff ? DIV_ONE : eff_div;

    // peripheral clock disables, all off until software turns them on
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pdn_ff <= PDN_RESET;
        end else if (i_pdn_wr) begin
            pdn_ff <= i_pdn_val;
        end
    end

    core_clock_divider u_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .tick(tick.divider)
    );

    periph_clock_gates u_gates (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .tick(tick.gates),
        .i_pdn(pdn_ff),
        .o_periph_tick(o_periph_clock),
        .o_gated(o_periph_clock_gated)
    );

    assign o_pll_feedback_multiplier = fb_mult_ff;
    assign o_input_halve_enable = halve_ff;
    assign o_pll_ref_tick = ref_tick_ff;
    assign o_core_clock = tick.core_tick;
    assign o_core_reset = core_reset_ff;
    assign o_bypass_active = bypass_ff;
    assign o_multiplier_field = mult_ff;
    assign o_divisor_field = div_ff;
    assign o_periph_pdn = pdn_ff;

    strap_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
        state_ff == ST_STRAP |=> mult_ff == strap_ratio($past(strap_s2_ff)))
        else $error("multiplier not loaded from straps");
    strap_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        state_ff == ST_RUN && !i_mult_wr |=> $stable(mult_ff))
        else $error("multiplier moved without a write");
    mult_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
        state_ff != ST_STRAP && i_mult_wr |=> mult_ff == $past(i_mult_val))
        else $error("multiplier write not taken");
    mult_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        mult_ff == 6'h00 |=> o_pll_feedback_multiplier == 7'h40)
        else $error("zero multiplier not shown as 64");
    halve_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ref_rise && !halve_ff |=> o_pll_ref_tick)
        else $error("undivided reference tick lost");
    halve_skip_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_pll_ref_tick && halve_ff && $past(halve_ff) |->
        $past(halve_phase_ff))
        else $error("halved reference ticks on wrong phase");
    div_reset_a: assert property (@(posedge i_clk)
        $past(i_rst) |-> div_ff == 4'h1)
        else $error("divisor field not one after reset");
    core_rst_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        settle_cnt_ff != 13'h1000 |=> o_core_reset)
        else $error("core reset released before settle count");
    core_rst_free_a: assert property (@(posedge i_clk) disable iff (i_rst)
        state_ff == ST_SETTLE && settle_cnt_ff == 13'h1000 |=> ##1
        !o_core_reset)
        else $error("core reset not released after settle count");
    bypass_path_a: assert property (@(posedge i_clk) disable iff (i_rst)
        bypass_ff |-> tick.src_tick == ref_rise && tick.divisor == 4'h1)
        else $error("bypass does not route the reference");
    bypass_clean_a: assert property (@(posedge i_clk) disable iff (i_rst)
        bypass_ff != $past(bypass_ff) |->
        $past(tick.core_tick) || $past(sw_wait_ff) == 6'h3f)
        else $error("bypass switched mid core period");
    pdn_reset_a: assert property (@(posedge i_clk)
        $past(i_rst) |-> pdn_ff == 8'hff)
        else $error("peripheral clocks not off after reset");

    run_reached_c: cover property (@(posedge i_clk) disable iff (i_rst)
        state_ff == ST_SETTLE ##1 state_ff == ST_RUN);
    bypass_enter_c: cover property (@(posedge i_clk) disable iff (i_rst)
        !bypass_ff ##1 bypass_ff);
    mult_zero_c: cover property (@(posedge i_clk) disable iff (i_rst)
        i_mult_wr && i_mult_val == 6'h00);
endmodule

// >>> verif/test_pll_clock_generator_control.sv
// self-checking testbench for the pll clock generator control block
`timescale 1ns/10ps
module test_pll_clock_generator_control
    import pll_ctrl_pkg::*;
;
    typedef struct {
        logic [1:0] strap;
        logic wr;
        logic [5:0] mval;
        logic [3:0] dval;
        logic [5:0] exp_mf;
        logic [6:0] exp_fb;
        int exp_gap;
    } row_t;

    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_reference_input_clock;
    logic i_vco_clock;
    logic [1:0] i_ratio_strap = 2'h0;
    logic i_input_halve_enable = 1'b0;
    logic i_pll_bypass_select = 1'b0;
    logic i_output_divisor_enable = 1'b1;
    logic i_mult_wr = 1'b0;
    logic [MULT_W-1:0] i_mult_val = 6'h00;
    logic i_div_wr = 1'b0;
    logic [DIV_W-1:0] i_div_val = 4'h1;
    logic i_pdn_wr = 1'b0;
    logic [NUM_PERIPH-1:0] i_pdn_val = 8'hff;
    logic [FB_MULT_W-1:0] o_pll_feedback_multiplier;
    logic o_input_halve_enable;
    logic o_pll_ref_tick;
    logic o_core_clock;
    logic o_periph_clock;
    logic [NUM_PERIPH-1:0] o_periph_clock_gated;
    logic o_core_reset;
    logic o_bypass_active;
    logic [MULT_W-1:0] o_multiplier_field;
    logic [DIV_W-1:0] o_divisor_field;
    logic [NUM_PERIPH-1:0] o_periph_pdn;
    int cyc = 0;
    int n_errors = 0;
    int total_checks = 0;
    int n_core = 0;
    int n_periph = 0;
    int n_g0 = 0;
    int n_g7 = 0;
    int g;
    int t;
    row_t rows [7];

    // reference rises every 4 cycles, vco every 2
    assign i_reference_input_clock = cyc[1];
    assign i_vco_clock = cyc[0];

    always #25 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        #5 cyc = cyc + 1;
    end

    // count pulses away from the launching edge so no race with the flops
    always @(negedge i_clk) begin
        if (o_core_clock === 1'b1) n_core = n_core + 1;
        if (o_periph_clock === 1'b1) n_periph = n_periph + 1;
        if (o_periph_clock_gated[0] === 1'b1) n_g0 = n_g0 + 1;
        if (o_periph_clock_gated[7] === 1'b1) n_g7 = n_g7 + 1;
        if (cyc == 60000) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: run did not finish", $time);
            tally_and_finish();
        end
    end

    pll_clock_generator_control dut (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_reference_input_clock(i_reference_input_clock),
        .i_vco_clock(i_vco_clock),
        .i_ratio_strap(i_ratio_strap),
        .i_input_halve_enable(i_input_halve_enable),
        .i_pll_bypass_select(i_pll_bypass_select),
        .i_output_divisor_enable(i_output_divisor_enable),
        .i_mult_wr(i_mult_wr),
        .i_mult_val(i_mult_val),
        .i_div_wr(i_div_wr),
        .i_div_val(i_div_val),
        .i_pdn_wr(i_pdn_wr),
        .i_pdn_val(i_pdn_val),
        .o_pll_feedback_multiplier(o_pll_feedback_multiplier),
        .o_input_halve_enable(o_input_halve_enable),
        .o_pll_ref_tick(o_pll_ref_tick),
        .o_core_clock(o_core_clock),
        .o_periph_clock(o_periph_clock),
        .o_periph_clock_gated(o_periph_clock_gated),
        .o_core_reset(o_core_reset),
        .o_bypass_active(o_bypass_active),
        .o_multiplier_field(o_multiplier_field),
        .o_divisor_field(o_divisor_field),
        .o_periph_pdn(o_periph_pdn)
    );

    task automatic tk(input int n);
        repeat (n) begin
            @(posedge i_clk);
            #5;
        end
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                             input string msg);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: %s got %h want %h", $time, msg,
                     got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi,
                               input string msg);
        total_checks = total_checks + 1;
        if (got < lo || got > hi) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: %s got %0d want %0d..%0d", $time,
                     msg, got, lo, hi);
        end
    endtask

    function automatic logic pulse(input int sel);
        return sel == 1 ? o_pll_ref_tick === 1'b1 : o_core_clock === 1'b1;
    endfunction

    // cycles between two successive pulses of the chosen output
    task automatic gap(input int sel, output int n);
        int w;
        w = 0;
        while (!pulse(sel) && w < 200) begin
            tk(1);
            w = w + 1;
        end
        tk(1);
        n = 1;
        while (!pulse(sel) && n < 200) begin
            tk(1);
            n = n + 1;
        end
    endtask

    task automatic do_reset(input logic [1:0] s);
        i_ratio_strap = s;
        i_rst = 1'b1;
        tk(20);
        i_rst = 1'b0;
    endtask

    task automatic write_fields(input logic wr, input logic [5:0] m,
                                input logic [3:0] d);
        i_mult_wr = wr;
        i_mult_val = m;
        i_div_wr = 1'b1;
        i_div_val = d;
        tk(1);
        i_mult_wr = 1'b0;
        i_div_wr = 1'b0;
    endtask

    task automatic wait_bypass(input logic v);
        t = 0;
        while (o_bypass_active !== v && t < 100) begin
            tk(1);
            t = t + 1;
        end
        check_val(o_bypass_active, v, "bypass state");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        rows[0] = '{2'h0, 1'b0, 6'h00, 4'h1, 6'h06, 7'h06, 2};
        rows[1] = '{2'h1, 1'b0, 6'h00, 4'h1, 6'h20, 7'h20, 2};
        rows[2] = '{2'h2, 1'b0, 6'h00, 4'h2, 6'h10, 7'h10, 4};
        rows[3] = '{2'h3, 1'b0, 6'h00, 4'h3, 6'h06, 7'h06, 6};
        rows[4] = '{2'h0, 1'b1, 6'h00, 4'h0, 6'h00, 7'h40, 2};
        rows[5] = '{2'h0, 1'b1, 6'h01, 4'hf, 6'h01, 7'h01, 30};
        rows[6] = '{2'h0, 1'b1, 6'h3f, 4'h4, 6'h3f, 7'h3f, 8};
        tk(20);
        check_val(o_multiplier_field, MULT_RESET, "mult reset");
        check_val(o_divisor_field, 4'h1, "div reset");
        check_val(o_periph_pdn, 8'hff, "pdn reset");
        check_val(o_core_reset, 1'b1, "core reset");
        check_val(o_bypass_active, 1'b0, "bypass reset");
        i_rst = 1'b0;
        n_periph = 0;
        n_g0 = 0;
        t = 0;
        while (o_core_reset === 1'b1 && t < 17000) begin
            tk(1);
            t = t + 1;
        end
        check_range(t, 16384, 16400, "internal reset length");
        check_val(n_g0, 0, "gated clock after reset");
        check_range(n_periph, 1, 100000, "periph clock runs");
        foreach (rows[i]) begin
            do_reset(rows[i].strap);
            tk(3);
            write_fields(rows[i].wr, rows[i].mval, rows[i].dval);
            tk(2);
            check_val(o_multiplier_field, rows[i].exp_mf, "mult field");
            check_val(o_pll_feedback_multiplier, rows[i].exp_fb, "fb mult");
            tk(100);
            gap(0, g);
            check_val(g, rows[i].exp_gap, "core period");
        end
        i_ratio_strap = 2'h1;
        tk(10);
        check_val(o_multiplier_field, 6'h3f, "strap after load");
        write_fields(1'b1, 6'h10, 4'h2);
        tk(40);
        write_fields(1'b0, 6'h10, 4'h5);
        for (int k = 0; k < 14; k++) begin
            gap(0, g);
            check_range(g, 1, 20, "core clock kept running");
        end
        check_val(g, 10, "new divisor adopted");
        write_fields(1'b0, 6'h10, 4'h1);
        i_pdn_wr = 1'b1;
        i_pdn_val = 8'h80;
        tk(1);
        i_pdn_wr = 1'b0;
        tk(40);
        check_val(o_periph_pdn, 8'h80, "pdn field");
        n_core = 0;
        n_periph = 0;
        n_g0 = 0;
        n_g7 = 0;
        tk(800);
        check_range(n_core, 399, 401, "core count");
        check_range(n_periph * 2, n_core - 2, n_core + 2, "periph half");
        check_val(n_g0, n_periph, "enabled gated clock");
        check_val(n_g7, 0, "disabled gated clock");
        write_fields(1'b0, 6'h10, 4'h3);
        i_output_divisor_enable = 1'b0;
        tk(10);
        gap(0, g);
        check_val(g, 2, "divisor disabled gives one");
        i_output_divisor_enable = 1'b1;
        tk(10);
        gap(0, g);
        check_val(g, 6, "divisor enabled again");
        gap(0, g);
        i_pll_bypass_select = 1'b1;
        wait_bypass(1'b1);
        gap(0, g);
        check_val(g, 4, "bypass core period");
        gap(1, g);
        check_val(g, 4, "reference tick");
        i_input_halve_enable = 1'b1;
        tk(3);
        check_val(o_input_halve_enable, 1'b1, "halve readback");
        gap(1, g);
        gap(1, g);
        check_val(g, 8, "halved reference tick");
        gap(0, g);
        check_val(g, 4, "bypass ignores halving");
        i_input_halve_enable = 1'b0;
        tk(16384);
        i_pll_bypass_select = 1'b0;
        wait_bypass(1'b0);
        tk(20);
        gap(0, g);
        check_val(g, 6, "core period after bypass");
        tally_and_finish();
    end
endmodule
